// >>> src/fcsm_pkg.sv
// Package for the flash command host controller.
// Assumes a 100 MHz system clock and a 16-bit asynchronous NOR flash.
package fcsm_pkg;
  localparam int CLK_NS = 10;
  // Avalon register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hc;
  // Control register fields
  localparam int CTRL_GO = 0;
  localparam int CTRL_OP_LSB = 4;
  localparam int CTRL_OP_W = 3;
  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_FAIL = 1;
  localparam int STAT_RDY = 2;
  localparam int STAT_WIN = 3;
  // Flash unlock and command codes
  localparam logic [21:0] ADDR_UNL1 = 22'h000555;
  localparam logic [21:0] ADDR_UNL2 = 22'h0002aa;
  localparam logic [15:0] DAT_UNL1 = 16'h00aa;
  localparam logic [15:0] DAT_UNL2 = 16'h0055;
  localparam logic [15:0] CMD_RESET = 16'h00f0;
  localparam logic [15:0] CMD_ID = 16'h0090;
  localparam logic [15:0] CMD_PROG = 16'h00a0;
  localparam logic [15:0] CMD_ERSETUP = 16'h0080;
  localparam logic [15:0] CMD_CHIP = 16'h0010;
  localparam logic [15:0] CMD_SECT = 16'h0030;
  localparam logic [15:0] CMD_SUSP = 16'h00b0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  // Status bit positions on the flash data bus, and the sector address LSB
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int FAIL_BIT = 5;
  localparam int WIN_BIT = 3;
  localparam int SECT_LSB = 16;
  // Bus timing
  localparam int T_STROBE_NS = 50;
  localparam int T_ACC_NS = 90;
  localparam int T_SECTWIN_US = 50;
  localparam int T_SUSP_US = 20;
  localparam logic [7:0] STROBE_CYC = 8'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam int SUSP_CYC = (T_SUSP_US * 1000) / CLK_NS;
  localparam int SECTWIN_CYC = (T_SECTWIN_US * 1000) / CLK_NS;
  typedef enum logic [2:0]
  {
    OP_READ = 3'b000,
    OP_RESET = 3'b001,
    OP_PROG = 3'b010,
    OP_CHIP = 3'b011,
    OP_SECT = 3'b100,
    OP_SUSP = 3'b101,
    OP_RESUME = 3'b110,
    OP_ID = 3'b111
  } fcsm_op_t;
endpackage

// >>> src/fcsm_cycle.sv
// One asynchronous flash bus cycle, write or read, timed in clk_sys counts.
// Assumes the flash is the only load on the strobes and data bus.
`timescale 1ns/100ps
module fcsm_cycle
  import fcsm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic start,
  input wire logic isWrite,
  input wire logic [21:0] addrIn,
  input wire logic [15:0] dataIn,
  output logic done,
  output logic [15:0] rdData,
  output logic [21:0] flashAddr,
  output logic chipSelN,
  output logic writeStrobeN,
  output logic outEnN,
  input wire logic [15:0] flashDqIn,
  output logic [15:0] flashDqOut,
  output logic flashDqOe
);
  typedef enum logic [1:0]
  {
    CY_IDLE = 2'b00,
    CY_ACT = 2'b01,
    CY_HOLD = 2'b10
  } fcsm_cy_t;
  fcsm_cy_t state;
  logic [7:0] cnt;
  logic wr;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state <= CY_IDLE;
      cnt <= 8'h00;
      done <= 1'b0;
      wr <= 1'b0;
      chipSelN <= 1'b1;
      writeStrobeN <= 1'b1;
      outEnN <= 1'b1;
      flashDqOe <= 1'b0;
      flashAddr <= 22'h000000;
      flashDqOut <= 16'h0000;
      rdData <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      unique case (state)
        CY_IDLE:
        begin
          if (start)
          begin
            // Address set on the same edge the strobes fall; data held past the rise
            flashAddr <= addrIn;
            flashDqOut <= dataIn;
            flashDqOe <= isWrite;
            wr <= isWrite;
            chipSelN <= 1'b0;
            writeStrobeN <= ~isWrite;
            outEnN <= isWrite;
            cnt <= isWrite ? STROBE_CYC : ACC_CYC;
            state <= CY_ACT;
          end
        end
        CY_ACT:
        begin
          if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
          else
          begin
            if (!wr)
              rdData <= flashDqIn;
            writeStrobeN <= 1'b1;
            chipSelN <= 1'b1;
            outEnN <= 1'b1;
            state <= CY_HOLD;
          end
        end
        CY_HOLD:
        begin
          flashDqOe <= 1'b0;
          done <= 1'b1;
          state <= CY_IDLE;
        end
        default:
          state <= CY_IDLE;
      endcase
    end
  end
endmodule

// >>> src/fcsm_host.sv
// What this block does
// - After identifier mode or a fail flag, only reset returns to read array.
// - Word program is two unlocks, program set-up, then address and data.
// - Erase is six writes: unlocks, 80H, unlocks, then 10H or 30H plus sector.
// - Further sector loads start within 50us of previous strobe rise; this block loads only one sector per command.
//
// Host controller for a parallel NOR flash; Avalon-MM slave with waitrequest.
// Assumes the flash pins are joined directly; inputs synchronous to clk_sys.
//
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/100ps
module fcsm_host
  import fcsm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  output logic [21:0] flashAddr,
  output logic chipSelN,
  output logic writeStrobeN,
  output logic outEnN,
  output logic flashResetN,
  input wire logic readyBusyN,
  input wire logic [15:0] flashDqIn,
  output logic [15:0] flashDqOut,
  output logic flashDqOe
);
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT = 3'b010,
    ST_POLL1 = 3'b011,
    ST_POLL2 = 3'b100,
    ST_DONE = 3'b101
  } fcsm_st_t;
  fcsm_st_t state;
  fcsm_op_t op;
  logic [21:0] opAddr;
  logic [15:0] opData;
  logic [2:0] step;
  logic [2:0] nSteps;
  logic cycStart;
  logic cycWrite;
  logic [21:0] cycAddr;
  logic [15:0] cycData;
  logic cycDone;
  logic [15:0] cycRd;
  logic [15:0] lastRd;
  logic [15:0] readResult;
  logic busy;
  logic failFlag;
  logic winFlag;
  logic pollNeeded;
  logic rdReady;

  // Number of bus writes per command sequence
  function automatic logic [2:0] seq_len(input fcsm_op_t o);
    unique case (o)
      OP_PROG: seq_len = 3'd4;
      OP_CHIP: seq_len = 3'd6;
      OP_SECT: seq_len = 3'd6;
      OP_ID: seq_len = 3'd3;
      default: seq_len = 3'd1;
    endcase
  endfunction

  // Address and data for step s of a sequence
  function automatic logic [37:0] seq_word(input fcsm_op_t o, input logic [2:0] s,
                                           input logic [21:0] a, input logic [15:0] d);
    logic eraseOp;
    eraseOp = (o == OP_CHIP) || (o == OP_SECT);
    seq_word = {ADDR_UNL1, CMD_RESET};
    unique case (o)
      OP_RESET: seq_word = {ADDR_UNL1, CMD_RESET};
      OP_SUSP: seq_word = {ADDR_UNL1, CMD_SUSP};
      OP_RESUME: seq_word = {ADDR_UNL1, CMD_RESUME};
      OP_READ: seq_word = {a, 16'h0000};
      default:
      begin
        if (s == 3'd0 || (eraseOp && s == 3'd3))
          seq_word = {ADDR_UNL1, DAT_UNL1};
        else if (s == 3'd1 || (eraseOp && s == 3'd4))
          seq_word = {ADDR_UNL2, DAT_UNL2};
        else if (s == 3'd2)
          seq_word = {ADDR_UNL1, (o == OP_PROG) ? CMD_PROG :
                                 (o == OP_ID) ? CMD_ID : CMD_ERSETUP};
        else if (o == OP_PROG)
          seq_word = {a, d};
        else if (o == OP_CHIP)
          seq_word = {ADDR_UNL1, CMD_CHIP};
        else
          seq_word = {a[21:SECT_LSB], 16'h0000, CMD_SECT};
      end
    endcase
  endfunction

  assign pollNeeded = (op == OP_PROG) || (op == OP_CHIP) || (op == OP_SECT);

  // Reads wait one cycle for registered data; CTRL writes stall while busy
  always_comb
  begin
    avsWaitrequest = 1'b0;
    if (avsRead && !rdReady)
      avsWaitrequest = 1'b1;
    if (avsWrite && avsAddress == REG_CTRL && busy)
      avsWaitrequest = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdReady <= 1'b0;
    else
      rdReady <= avsRead && !rdReady;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      avsReaddata <= 32'h00000000;
    else if (avsRead && !rdReady)
    begin
      unique case (avsAddress)
        REG_CTRL: avsReaddata <= {25'h0000000, op, 3'b000, busy};
        REG_ADDR: avsReaddata <= {10'h000, opAddr};
        REG_DATA: avsReaddata <= {16'h0000, readResult};
        REG_STAT: avsReaddata <= {28'h0000000, winFlag, readyBusyN, failFlag, busy};
        default: avsReaddata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      opAddr <= 22'h000000;
      opData <= 16'h0000;
    end
    else if (avsWrite && !avsWaitrequest)
    begin
      if (avsAddress == REG_ADDR)
        opAddr <= avsWritedata[21:0];
      if (avsAddress == REG_DATA)
        opData <= avsWritedata[15:0];
    end
  end

  // Sequencer
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state <= ST_IDLE;
      op <= OP_READ;
      step <= 3'd0;
      nSteps <= 3'd1;
      busy <= 1'b0;
      cycStart <= 1'b0;
      cycWrite <= 1'b0;
      cycAddr <= 22'h000000;
      cycData <= 16'h0000;
      lastRd <= 16'h0000;
      readResult <= 16'h0000;
      failFlag <= 1'b0;
      winFlag <= 1'b0;
    end
    else
    begin
      cycStart <= 1'b0;
      unique case (state)
        ST_IDLE:
        begin
          if (avsWrite && avsAddress == REG_CTRL && avsWritedata[CTRL_GO])
          begin
            op <= fcsm_op_t'(avsWritedata[CTRL_OP_LSB +: CTRL_OP_W]);
            nSteps <= seq_len(fcsm_op_t'(avsWritedata[CTRL_OP_LSB +: CTRL_OP_W]));
            step <= 3'd0;
            busy <= 1'b1;
            failFlag <= 1'b0;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE:
        begin
          {cycAddr, cycData} <= seq_word(op, step, opAddr, opData);
          cycWrite <= (op != OP_READ);
          cycStart <= 1'b1;
          state <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (cycDone)
          begin
            if (op == OP_READ)
            begin
              // In suspend, a read of the erasing sector returns status
              readResult <= cycRd;
              state <= ST_DONE;
            end
            else if (step + 3'd1 < nSteps)
            begin
              step <= step + 3'd1;
              state <= ST_ISSUE;
            end
            else if (pollNeeded)
            begin
              cycAddr <= (op == OP_SECT) ? opAddr : cycAddr;
              cycWrite <= 1'b0;
              cycStart <= 1'b1;
              state <= ST_POLL1;
            end
            else
              state <= ST_DONE;
          end
        end
        ST_POLL1:
        begin
          if (cycDone)
          begin
            lastRd <= cycRd;
            cycStart <= 1'b1;
            state <= ST_POLL2;
          end
        end
        ST_POLL2:
        begin
          if (cycDone)
          begin
            winFlag <= cycRd[WIN_BIT];
            lastRd <= cycRd;
            // Finished when toggle stops across two reads
            if (cycRd[TOGGLE_BIT] == lastRd[TOGGLE_BIT])
            begin
              readResult <= cycRd;
              state <= ST_DONE;
            end
            // Fail only when both toggling reads carry the fail bit
            else if (cycRd[FAIL_BIT] && lastRd[FAIL_BIT])
            begin
              failFlag <= 1'b1;
              readResult <= cycRd;
              state <= ST_DONE;
            end
            else
              cycStart <= 1'b1;
          end
        end
        ST_DONE:
        begin
          busy <= 1'b0;
          winFlag <= 1'b0;
          state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  assign flashResetN = ~srst;

  fcsm_cycle u_cycle
  (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(cycStart),
    .isWrite(cycWrite),
    .addrIn(cycAddr),
    .dataIn(cycData),
    .done(cycDone),
    .rdData(cycRd),
    .flashAddr(flashAddr),
    .chipSelN(chipSelN),
    .writeStrobeN(writeStrobeN),
    .outEnN(outEnN),
    .flashDqIn(flashDqIn),
    .flashDqOut(flashDqOut),
    .flashDqOe(flashDqOe)
  );

  // Strobe and read enable never both low
  strobe_excl_a: assert property (@(posedge clk_sys) disable iff (srst)
    !(!writeStrobeN && !outEnN))
    else $error("write strobe and output enable low together");

  // Data driven while write strobe low
  data_drive_a: assert property (@(posedge clk_sys) disable iff (srst)
    !writeStrobeN |-> flashDqOe)
    else $error("data not driven during write strobe");

  // Program sequence fourth write carries target address
  prog_addr_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state == ST_ISSUE && op == OP_PROG && step == 3'd3) |=> (cycAddr == opAddr))
    else $error("program address not on bus");

  sequence sectWrite_s;
    state == ST_ISSUE && op == OP_SECT && step == 3'd5;
  endsequence
  sect_cmd_a: assert property (@(posedge clk_sys) disable iff (srst)
    sectWrite_s |=> (cycData == CMD_SECT && cycAddr[15:0] == 16'h0000))
    else $error("sector erase word wrong");

  chip_cmd_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state == ST_ISSUE && op == OP_CHIP && step == 3'd2) |=> (cycData == CMD_ERSETUP))
    else $error("erase set-up code wrong");

  busy_wait_a: assert property (@(posedge clk_sys) disable iff (srst)
    (busy && avsWrite && avsAddress == REG_CTRL) |-> avsWaitrequest)
    else $error("command taken while busy");

  suspend_code_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state == ST_ISSUE && op == OP_SUSP) |=> (cycData == CMD_SUSP))
    else $error("suspend code wrong");

  reset_code_a: assert property (@(posedge clk_sys) disable iff (srst)
    (state == ST_ISSUE && op == OP_RESET) |=> (cycData == CMD_RESET && cycWrite))
    else $error("reset code wrong");
endmodule

// >>> tb/fcsm_flash_model.sv
// Behavioural parallel NOR flash standing on the far side of the host.
// Assumes the host's split data bus; clockless, self-timed in 10 ns ticks.
`timescale 1ns/100ps
module fcsm_flash_model
  import fcsm_pkg::*;
#(
  parameter int OP_TICKS = 30,
  parameter logic [15:0] MAKER = 16'h00a5, // Arbitrary value
  parameter logic [15:0] PART = 16'h5a3c, // Arbitrary value
  parameter logic [7:0] SEC_IND = 8'h18
)
(
  input wire logic [21:0] flashAddr,
  input wire logic chipSelN,
  input wire logic writeStrobeN,
  input wire logic outEnN,
  input wire logic flashResetN,
  input wire logic [15:0] hostDq,
  input wire logic hostOe,
  output logic readyBusyN,
  output logic [15:0] busDq
);
  logic [15:0] mem [0:255];
  logic [21:0] la;
  logic [2:0] seq;
  logic [1:0] kind;
  logic idMode, busy, susp, tog, pollB;
  logic [5:0] sect;
  logic [15:0] stat, idWord, rdVal, rdDel;
  int cnt;
  wire wrN = chipSelN | writeStrobeN | ~outEnN;
  wire win = busy && kind == 2'h3 && cnt > OP_TICKS - 5;
  wire u1 = hostDq[7:0] == 8'haa && la[10:0] == 11'h555;
  wire u2 = hostDq[7:0] == 8'h55 && la[10:0] == 11'h2aa;
  initial
  begin
    foreach (mem[i]) mem[i] = 16'hffff;
    {seq, kind, idMode, busy, susp, tog, pollB, sect, cnt} = '0;
  end
  // Sector from the top six address bits, word from the low two
  function automatic logic [7:0] idx(input logic [21:0] a);
    return {a[21:16], a[1:0]};
  endfunction
  task automatic start(input logic [1:0] k, input logic p);
    kind = k;
    pollB = p;
    sect = la[21:16];
    cnt = OP_TICKS;
    busy = 1'b1;
  endtask
  always @(negedge wrN) la = flashAddr;
  always @(posedge wrN or negedge flashResetN)
  begin
    if (!flashResetN)
      {seq, idMode, busy, susp} = '0;
    else if (busy)
    begin
      if (hostDq[7:0] == 8'hb0 && kind == 2'h3)
      begin
        susp = 1'b1;
        busy = 1'b0;
      end
    end
    else if (hostDq[7:0] == 8'hf0)
      {seq, idMode} = '0;
    else if (susp && seq == 3'h0 && hostDq[7:0] == 8'h30)
      {susp, busy} = 2'b01;
    else
      case (seq)
        3'h0, 3'h4: seq = u1 ? seq + 3'h1 : 3'h0;
        3'h1, 3'h5: seq = u2 ? seq + 3'h1 : 3'h0;
        3'h2:
        begin
          idMode = idMode | hostDq[7:0] == 8'h90;
          seq = hostDq[7:0] == 8'ha0 ? 3'h3 : hostDq[7:0] == 8'h80 ? 3'h4 : 3'h0;
        end
        3'h3:
        begin
          mem[idx(la)] = mem[idx(la)] & hostDq;
          start(2'h1, ~hostDq[7]);
          seq = 3'h0;
        end
        default:
        begin
          if (hostDq[7:0] == 8'h10 || hostDq[7:0] == 8'h30)
            start(hostDq[7:0] == 8'h10 ? 2'h2 : 2'h3, 1'b0);
          seq = 3'h0;
        end
      endcase
  end
  always #10
  begin
    if (busy && cnt == 0)
    begin
      foreach (mem[i])
        if (kind == 2'h2 || (kind == 2'h3 && i[7:2] == sect)) mem[i] = 16'hffff;
      busy = 1'b0;
    end
    else if (busy)
      cnt--;
  end
  always @(negedge outEnN) if (!chipSelN && busy) tog = ~tog;
  assign readyBusyN = ~busy;
  assign stat = {8'h00, pollB, tog, 2'b00, win, tog, 2'b00};
  assign idWord = flashAddr[1:0] == 2'h0 ? MAKER : flashAddr[1:0] == 2'h1 ? PART
    : flashAddr[1:0] == 2'h2 ? 16'h0000 : {8'h00, SEC_IND};
  assign rdVal = busy || (susp && flashAddr[21:16] == sect) ? stat
    : idMode ? idWord : mem[idx(flashAddr)];
  assign #80 rdDel = rdVal;
  // Undriven bus shows the inverse of its last level
  always @(hostOe or hostDq or chipSelN or outEnN or rdDel)
    busDq = hostOe ? hostDq : !chipSelN && !outEnN ? rdDel : ~busDq;
endmodule

// >>> tb/flash_command_state_machine_test.sv
// Self-checking bench for the flash host controller.
// Assumes the behavioural flash model on the far side of the pins.
`timescale 1ns/100ps
module flash_command_state_machine_test
  import fcsm_pkg::*;
;
  localparam logic [15:0] MAKER_CODE = 16'h00a5; // Arbitrary value
  localparam logic [15:0] PART_CODE = 16'h5a3c; // Arbitrary value
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest, chipSelN, writeStrobeN, outEnN, flashResetN, readyBusyN, flashDqOe;
  logic [21:0] flashAddr;
  logic [15:0] flashDqIn, flashDqOut;
  int failCount = 0;
  int nTests = 0;
  fcsm_host dut_u (.clk_sys(clk_sys), .srst(srst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .flashAddr(flashAddr),
    .chipSelN(chipSelN), .writeStrobeN(writeStrobeN), .outEnN(outEnN),
    .flashResetN(flashResetN), .readyBusyN(readyBusyN), .flashDqIn(flashDqIn),
    .flashDqOut(flashDqOut), .flashDqOe(flashDqOe));
  fcsm_flash_model #(.MAKER(MAKER_CODE), .PART(PART_CODE)) flash_u (.flashAddr(flashAddr),
    .chipSelN(chipSelN), .writeStrobeN(writeStrobeN), .outEnN(outEnN),
    .flashResetN(flashResetN), .hostDq(flashDqOut), .hostOe(flashDqOe),
    .readyBusyN(readyBusyN), .busDq(flashDqIn));
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      failCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic busWr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= 1'b1;
    @(posedge clk_sys);
    while (avsWaitrequest !== 1'b0) @(posedge clk_sys);
    avsWrite <= 1'b0;
  endtask
  task automatic busRd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    avsAddress <= a;
    avsRead <= 1'b1;
    @(posedge clk_sys);
    while (avsWaitrequest !== 1'b0) @(posedge clk_sys);
    d = avsReaddata;
    avsRead <= 1'b0;
  endtask
  task automatic runOp(input fcsm_op_t op, input logic [21:0] a, input logic [15:0] d);
    logic [31:0] s;
    busWr(REG_ADDR, {10'h000, a});
    busWr(REG_DATA, {16'h0000, d});
    busWr(REG_CTRL, (32'(op) << CTRL_OP_LSB) | 32'h00000001);
    do busRd(REG_STAT, s); while (s[STAT_BUSY] !== 1'b0);
    check("status fail", 32'h0, 32'(s[STAT_FAIL]));
    check("ready pin", 32'h1, 32'(s[STAT_RDY]));
    check("window closed", 32'h0, 32'(s[STAT_WIN]));
  endtask
  task automatic readWord(input logic [21:0] a, input logic [15:0] exp, input string what);
    logic [31:0] d;
    runOp(OP_READ, a, 16'h0000);
    busRd(REG_DATA, d);
    check(what, {16'h0000, exp}, d);
  endtask
  task automatic tcPowerUp();
    logic [31:0] d;
    check("idle strobes", 32'h7, {29'h0, chipSelN, writeStrobeN, outEnN});
    readWord(22'h000010, 16'hffff, "power-up array");
    busRd(REG_ADDR, d);
    check("address readback", 32'h00000010, d);
  endtask
  task automatic tcProgram();
    runOp(OP_PROG, 22'h030001, 16'h1234);
    readWord(22'h030001, 16'h1234, "programmed word");
    runOp(OP_PROG, 22'h030001, 16'h4321);
    readWord(22'h030001, 16'h1234 & 16'h4321, "no zero to one");
  endtask
  task automatic tcIdent();
    runOp(OP_ID, 22'h000000, 16'h0000);
    readWord(22'h000000, MAKER_CODE, "maker code");
    readWord(22'h000001, PART_CODE, "part code");
    readWord(22'h030002, 16'h0000, "protect state");
    readWord(22'h000003, 16'h0018, "secured indicator");
    readWord(22'h030000, MAKER_CODE, "still identifying");
    runOp(OP_RESET, 22'h000000, 16'h0000);
    readWord(22'h030001, 16'h0220, "array after reset");
  endtask
  task automatic tcErase();
    runOp(OP_PROG, 22'h050001, 16'h00ff);
    runOp(OP_SECT, 22'h030000, 16'h0000);
    readWord(22'h030001, 16'hffff, "sector erased");
    readWord(22'h050001, 16'h00ff, "other sector");
    runOp(OP_SUSP, 22'h000000, 16'h0000);
    runOp(OP_RESUME, 22'h000000, 16'h0000);
    readWord(22'h050001, 16'h00ff, "idle suspend");
    runOp(OP_CHIP, 22'h000000, 16'h0000);
    readWord(22'h050001, 16'hffff, "chip erased");
  endtask
  task automatic tcAbort();
    busWr(REG_ADDR, 32'h00070002);
    busWr(REG_DATA, 32'h00000000);
    busWr(REG_CTRL, (32'(OP_PROG) << CTRL_OP_LSB) | 32'h00000001);
    while (readyBusyN !== 1'b0) @(posedge clk_sys);
    srst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("reset aborts", 32'h1, 32'(readyBusyN));
    srst <= 1'b0;
    readWord(22'h050001, 16'hffff, "after abort");
  endtask
  initial
  begin
    #500000;
    failCount++;
    conclude();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys);
    srst <= 1'b0;
    tcPowerUp();
    tcProgram();
    tcIdent();
    tcErase();
    tcAbort();
    conclude();
  end
endmodule
